/* File: lio_checker.sv */
// Purpose: wire-level checks on the bus between the led device and its controller
// Assumes: one clock domain; the interface resolves the pull-ups
// Notes:   device inputs lag scl by a short filter, well inside one quarter
module lio_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // resolved lines
  input wire logic scl_line,
  input wire logic sda_line,
  // controller drivers
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  // device drivers
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] high_run_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // cycles since scl was last low; a device left driving after stop would stall the bus
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_run_r <= 8'hff;
    end else if (!scl_line) begin
      high_run_r <= 8'h00;
    end else if (high_run_r != 8'hff) begin
      high_run_r <= high_run_r + 8'h01;
    end
  end

  chk_dev_pull_low: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drives sda high");
  chk_scl_pull_low: assert property (scl_m_oe |-> !scl_m_o)
    else $error("controller drives scl high");
  chk_sda_pull_low: assert property (sda_m_oe |-> !sda_m_o)
    else $error("controller drives sda high");
  chk_dev_change_low: assert property ($changed(sda_s_oe) |-> !scl_line)
    else $error("device changed sda while scl high");
  chk_scl_high_len: assert property ($rose(scl_line) |-> scl_line[*8])
    else $error("scl high phase too short");
  chk_scl_low_len: assert property ($fell(scl_line) |-> !scl_line[*8])
    else $error("scl low phase too short");
  chk_restart_free: assert property ($fell(sda_line) && scl_line && $past(scl_line) |-> !sda_s_oe)
    else $error("device held sda at a start");
  chk_dev_release: assert property (sda_s_oe |-> high_run_r < 8'd60)
    else $error("device kept sda after the frame");

  cov_dev_ack: cover property ($rose(sda_s_oe));
  cov_restart: cover property ($fell(sda_line) && scl_line && $past(scl_line));
  cov_stop: cover property ($rose(sda_line) && scl_line && $past(scl_line));
endmodule

/* File: lio_device.sv */
// Purpose: i2c slave with indexed registers, blink rates and open-drain led pins
// Assumes: scl and led pins are asynchronous and pass a three-flop filter
// Notes:   duty uses the dimmer sense (duty/256 is the on fraction)
//
// Our own choices: the register offsets and the AHB-Lite register port.
module lio_device
  import lio_pkg::*;
#(
  parameter int unsigned STEP_CYC = BLINK_STEP_CYC
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // two-wire bus
  lio_if.device                    bus,
  // led pins
  output logic [NUM_LEDS-1:0]      led_drv,
  output logic [NUM_LEDS-1:0]      led_oe,
  input  wire logic [NUM_LEDS-1:0] led_sense
);
  localparam int unsigned NPIN = NUM_LEDS + 2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WRITE, ST_ACK_WRITE, ST_READ, ST_MST_ACK
  } lio_dev_state_t;

  lio_dev_state_t  state_r;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] flt_r;
  logic            scl_q_r;
  logic            sda_q_r;
  logic            scl;
  logic            sda;
  logic            start_ev;
  logic            stop_ev;
  logic            scl_rise;
  logic            scl_fall;
  logic [3:0]      cnt_r;
  logic [7:0]      sh_r;
  logic [7:0]      tx_r;
  logic            rw_r;
  logic            first_r;
  logic            mack_r;
  logic            sda_oe_r;
  logic [7:0]      ctrl_r;
  logic [7:0]      regs_r [IDX_R1_PSC:IDX_SELECT];
  logic [3:0]      idx;
  logic            ai;
  logic [3:0]      idx_nxt;
  logic [7:0]      rd_data;
  logic            wr_done;
  logic            rd_done;
  logic [NUM_LEDS-1:0] pin_lvl;
  logic [31:0]     step_cnt_r;
  logic            step_en_r;
  logic [1:0]      blink_on;
  logic [NUM_LEDS-1:0] led_oe_r;

  // pin filter: a change counts once the second and third flop agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= '1;
      s2_r    <= '1;
      s3_r    <= '1;
      flt_r   <= '1;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      s1_r    <= {led_sense, bus.scl_line, bus.sda_line};
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      flt_r   <= (s2_r & ~(s2_r ^ s3_r)) | (flt_r & (s2_r ^ s3_r));
      scl_q_r <= flt_r[1];
      sda_q_r <= flt_r[0];
    end
  end

  assign scl      = flt_r[1];
  assign sda      = flt_r[0];
  assign pin_lvl  = flt_r[NPIN-1:2];
  assign start_ev = scl & scl_q_r & sda_q_r & ~sda;
  assign stop_ev  = scl & scl_q_r & ~sda_q_r & sda;
  assign scl_rise = scl & ~scl_q_r;
  assign scl_fall = ~scl & scl_q_r;

  assign idx = ctrl_r[CTRL_IDX_LSB +: CTRL_IDX_W];
  assign ai  = ctrl_r[CTRL_AI_BIT]; // RULE_13
  // past the last register the index rolls over to zero
  assign idx_nxt = (idx >= IDX_MAX) ? 4'h0 : idx + 4'h1; // RULE_02

  // read source picked by the index as it stands, before any advance
  always_comb begin
    rd_data = 8'h00;
    if (idx == IDX_INPUT) begin
      rd_data = {{(8-NUM_LEDS){1'b0}}, pin_lvl}; // RULE_08
    end else if (idx <= IDX_MAX) begin
      rd_data = regs_r[idx]; // RULE_14
    end
  end

  assign wr_done = (state_r == ST_WRITE) & scl_fall & (cnt_r == 4'd8);
  assign rd_done = (state_r == ST_READ) & scl_fall & (cnt_r == 4'd8);

  // byte-level protocol engine: shift on scl rise, drive sda after scl fall
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 4'h0;
      sh_r     <= 8'h00;
      tx_r     <= 8'h00;
      rw_r     <= 1'b0;
      first_r  <= 1'b0;
      mack_r   <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      state_r  <= ST_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      state_r  <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        ST_ADDR, ST_WRITE: begin
          sh_r  <= {sh_r[6:0], sda};
          cnt_r <= cnt_r + 4'h1;
        end
        ST_MST_ACK: mack_r <= ~sda;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_r)
        ST_ADDR: begin
          if (cnt_r == 4'd8) begin
            if (sh_r[7:1] == DEV_ADDR) begin
              state_r  <= ST_ACK_ADDR;
              sda_oe_r <= 1'b1; // RULE_04
              rw_r     <= sh_r[0];
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (rw_r) begin
            tx_r     <= rd_data;
            sda_oe_r <= ~rd_data[7];
            cnt_r    <= 4'h1;
            state_r  <= ST_READ; // RULE_04
          end else begin
            sda_oe_r <= 1'b0;
            cnt_r    <= 4'h0;
            first_r  <= 1'b1;
            state_r  <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (cnt_r == 4'd8) begin
            sda_oe_r <= 1'b1;
            state_r  <= ST_ACK_WRITE;
          end
        end
        ST_ACK_WRITE: begin
          sda_oe_r <= 1'b0;
          cnt_r    <= 4'h0;
          first_r  <= 1'b0;
          state_r  <= ST_WRITE;
        end
        ST_READ: begin
          if (cnt_r == 4'd8) begin
            sda_oe_r <= 1'b0;
            state_r  <= ST_MST_ACK;
          end else begin
            sda_oe_r <= ~tx_r[3'd7 - cnt_r[2:0]];
            cnt_r    <= cnt_r + 4'h1;
          end
        end
        ST_MST_ACK: begin
          // acked: next byte from the index as it now stands, advanced only with auto-increment; nack ends the read
          if (mack_r) begin
            tx_r     <= rd_data; // RULE_05
            sda_oe_r <= ~rd_data[7];
            cnt_r    <= 4'h1;
            state_r  <= ST_READ;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // control register: first written byte, then index advances when auto-increment is set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_done & first_r) begin
      ctrl_r <= sh_r; // RULE_14
    end else if ((wr_done | rd_done) & ai) begin
      ctrl_r[CTRL_IDX_LSB +: CTRL_IDX_W] <= idx_nxt; // RULE_01
    end
  end

  // data registers; the input register ignores writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r[IDX_R1_PSC]  <= PSC_RST;
      regs_r[IDX_R1_DUTY] <= DUTY_RST;
      regs_r[IDX_R2_PSC]  <= PSC_RST;
      regs_r[IDX_R2_DUTY] <= DUTY_RST;
      regs_r[IDX_SELECT]  <= SEL_RST;
    end else if (wr_done & ~first_r & (idx != IDX_INPUT) & (idx <= IDX_MAX)) begin
      regs_r[idx] <= sh_r;
    end
  end

  // step divider: one pulse per prescaler step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt_r <= 32'h0;
      step_en_r  <= 1'b0;
    end else if (step_cnt_r == 32'(STEP_CYC - 1)) begin
      step_cnt_r <= 32'h0;
      step_en_r  <= 1'b1;
    end else begin
      step_cnt_r <= step_cnt_r + 32'h1;
      step_en_r  <= 1'b0;
    end
  end

  // two blink rates; period (psc+1) steps, so never beyond 256 steps
  for (genvar r = 0; r < 2; r++) begin : g_rate
    logic [7:0]  ph_r;
    logic [7:0]  psc;
    logic [7:0]  duty;
    logic [15:0] lim;
    assign psc  = regs_r[IDX_R1_PSC + 4'(2 * r)];
    assign duty = regs_r[IDX_R1_DUTY + 4'(2 * r)];
    assign lim  = 16'({8'h00, psc} * {8'h00, duty} + {8'h00, duty});
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        ph_r <= 8'h00;
      end else if (step_en_r) begin
        ph_r <= (ph_r >= psc) ? 8'h00 : ph_r + 8'h01; // RULE_11
      end
    end
    assign blink_on[r] = {ph_r, 8'h00} < lim;
  end

  // each pin registered on its own; no cross-pin synchronisation
  for (genvar i = 0; i < NUM_LEDS; i++) begin : g_led
    logic [1:0] sel;
    logic       pull_r;
    assign sel = regs_r[IDX_SELECT][2*i +: 2];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        pull_r <= 1'b0;
      end else begin
        pull_r <= (sel == SEL_LOW) // RULE_06
                | ((sel == SEL_RATE1) & blink_on[0]) // RULE_12
                | ((sel == SEL_RATE2) & blink_on[1]); // RULE_07 RULE_10
      end
    end
    assign led_oe_r[i] = pull_r;
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_drv <= '0; // RULE_09
    end else begin
      led_drv <= '0;
    end
  end

  assign led_oe       = led_oe_r;
  assign bus.sda_s_oe = sda_oe_r;
  assign bus.sda_s_o  = 1'b0;
endmodule

/* File: lio_host.sv */
// Purpose: i2c controller taking byte commands from an ahb-lite register pair
// Assumes: single slave on the bus, zero-wait ahb answers
// Notes:   software builds reads and bursts from start, write, read, stop
module lio_host
  import lio_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // two-wire bus
  lio_if.host              bus
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} lio_host_state_t;

  lio_host_state_t st_r;
  logic        dph_wr_r;
  logic [7:0]  dph_addr_r;
  logic [31:0] hrdata_r;
  logic        s1_r, s2_r, s3_r, sda_f_r;
  logic [31:0] div_r;
  logic        tick_r;
  logic [1:0]  ph_r;
  logic [3:0]  bitn_r;
  logic [7:0]  txb_r;
  logic [7:0]  rx_r;
  logic        rd_r;
  logic        nack_r;
  logic        noack_r;
  logic        refused_r;
  logic        scl_oe_r;
  logic        sda_oe_r;
  logic [1:0]  byte_no_r;
  logic        addr_rd_r;
  logic [7:0]  ctrl_seen_r;
  logic        cmd_go;
  logic        refuse;
  lio_op_t     op;

  // ahb address phase captured, zero-wait data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dph_wr_r   <= 1'b0;
      dph_addr_r <= 8'h00;
      hrdata_r   <= 32'h0;
    end else if (hready) begin
      dph_wr_r   <= hsel & htrans[1] & hwrite;
      dph_addr_r <= haddr[7:0];
      if (hsel & htrans[1] & ~hwrite) begin
        hrdata_r <= (haddr[7:0] == HOST_STAT_OFS) ?
                    {16'h0, rx_r, 5'h0, refused_r, noack_r, st_r != H_IDLE} : 32'h0;
      end
    end
  end

  assign op     = lio_op_t'(hwdata[CMD_OP_LSB +: 2]);
  assign cmd_go = dph_wr_r & (dph_addr_r == HOST_CMD_OFS) & (st_r == H_IDLE);
  // an auto-increment read may not begin at index zero
  assign refuse = (op == OP_WRITE) & (byte_no_r == 2'd0) & hwdata[0]
                & ctrl_seen_r[CTRL_AI_BIT] & (ctrl_seen_r[CTRL_IDX_LSB +: CTRL_IDX_W] == 4'h0); // RULE_03

  // sda filter, same three-flop scheme as the device
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 1'b1;
      s2_r    <= 1'b1;
      s3_r    <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      s1_r    <= bus.sda_line;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      sda_f_r <= (s2_r == s3_r) ? s2_r : sda_f_r;
    end
  end

  // quarter scl period enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == 32'(SCL_QUARTER_CYC - 1));
      div_r  <= (div_r == 32'(SCL_QUARTER_CYC - 1)) ? 32'h0 : div_r + 32'h1;
    end
  end

  // transfer tracking: address byte, then control byte of a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_no_r   <= 2'd0;
      addr_rd_r   <= 1'b0;
      ctrl_seen_r <= 8'h00;
      refused_r   <= 1'b0;
    end else if (cmd_go) begin
      if (op == OP_START) begin
        byte_no_r <= 2'd0;
        refused_r <= 1'b0;
      end
      if ((op == OP_WRITE) & refuse) begin
        refused_r <= 1'b1;
      end else if ((op == OP_WRITE) | (op == OP_READ)) begin
        if (byte_no_r == 2'd0) addr_rd_r <= hwdata[0];
        if ((byte_no_r == 2'd1) & ~addr_rd_r) ctrl_seen_r <= hwdata[7:0]; // RULE_04
        if (byte_no_r != 2'd3) byte_no_r <= byte_no_r + 2'd1;
      end
    end
  end

  // bit engine: phases 0..3 per bit, scl high in phases 1 and 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r     <= H_IDLE;
      ph_r     <= 2'd0;
      bitn_r   <= 4'h0;
      txb_r    <= 8'h00;
      rx_r     <= 8'h00;
      rd_r     <= 1'b0;
      nack_r   <= 1'b0;
      noack_r  <= 1'b0;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (cmd_go) begin
      ph_r   <= 2'd0;
      bitn_r <= 4'h0;
      txb_r  <= hwdata[CMD_DATA_LSB +: 8];
      rd_r   <= (op == OP_READ);
      nack_r <= hwdata[CMD_NACK_BIT]; // RULE_05
      case (op)
        OP_START: st_r <= H_START;
        OP_STOP:  st_r <= H_STOP;
        OP_WRITE: st_r <= refuse ? H_IDLE : H_BIT;
        OP_READ:  st_r <= H_BIT;
        default:  st_r <= H_IDLE;
      endcase
    end else if (tick_r) begin
      ph_r <= ph_r + 2'd1;
      case (st_r)
        H_START: begin
          case (ph_r)
            2'd0: sda_oe_r <= 1'b0;
            2'd1: scl_oe_r <= 1'b0;
            2'd2: sda_oe_r <= 1'b1;
            default: begin
              scl_oe_r <= 1'b1;
              st_r     <= H_IDLE;
            end
          endcase
        end
        H_BIT: begin
          case (ph_r)
            2'd0: sda_oe_r <= (bitn_r == 4'd8) ? (rd_r & ~nack_r) : (~rd_r & ~txb_r[3'd7 - bitn_r[2:0]]);
            2'd1: scl_oe_r <= 1'b0;
            2'd2: begin
              if (bitn_r == 4'd8) begin
                if (!rd_r) noack_r <= sda_f_r;
              end else begin
                rx_r <= {rx_r[6:0], sda_f_r};
              end
            end
            default: begin
              scl_oe_r <= 1'b1;
              bitn_r   <= bitn_r + 4'h1;
              if (bitn_r == 4'd8) st_r <= H_IDLE;
            end
          endcase
        end
        H_STOP: begin
          case (ph_r)
            2'd0: sda_oe_r <= 1'b1;
            2'd1: scl_oe_r <= 1'b0;
            default: begin
              sda_oe_r <= 1'b0;
              st_r     <= H_IDLE;
            end
          endcase
        end
        default: ph_r <= 2'd0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata       = hrdata_r;
  assign bus.scl_m_oe = scl_oe_r;
  assign bus.scl_m_o  = 1'b0;
  assign bus.sda_m_oe = sda_oe_r;
  assign bus.sda_m_o  = 1'b0;
endmodule

/* File: lio_if.sv */
// Purpose: two-wire bus between the led device and its controller
// Assumes: external pull-ups, so an undriven line reads high
// Notes:   only the controller drives scl; no clock stretching
interface lio_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = scl_m_oe ? scl_m_o : 1'b1;
  assign sda_line = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport device (input scl_line, input sda_line, output sda_s_o, output sda_s_oe);
  modport host   (input sda_line, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
endinterface

/* File: lio_pkg.sv */
// Purpose: shared constants for the led output i2c slave and its bus controller
// Assumes: 10 MHz clock, four-output device, one variant chosen by OUT_DIMMER
// Notes:   How it works list below; tags mark the logic in the device and host files
//
// How it works
// RULE_01: auto-increment advances index after each returned byte
// RULE_02: index wraps to zero after its maximum
// RULE_03: auto-increment read must start at nonzero index
// RULE_04: single read: write index, restart, read one
// RULE_05: burst read: index with flag, restart, read on
// RULE_06: selector field works as general-purpose output
// RULE_07: release code switches pull-down off for input
// RULE_08: input register returns live pin levels
// RULE_09: outputs only pull low, high is released
// RULE_10: pins may switch at different moments
// RULE_11: dimmer blink period at most 1.6 seconds
// RULE_12: codes 10 and 11 blink at rate one/two
// RULE_13: control bit 4 is the auto-increment flag
// RULE_14: control low bits hold the register index
package lio_pkg;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam bit          OUT_DIMMER    = 1'b1;
  localparam int unsigned NUM_LEDS      = 4;
  localparam logic [6:0]  DEV_ADDR      = 7'h60;

  // register indices
  localparam logic [3:0] IDX_INPUT     = 4'h0;
  localparam logic [3:0] IDX_R1_PSC    = 4'h1;
  localparam logic [3:0] IDX_R1_DUTY   = 4'h2;
  localparam logic [3:0] IDX_R2_PSC    = 4'h3;
  localparam logic [3:0] IDX_R2_DUTY   = 4'h4;
  localparam logic [3:0] IDX_SELECT    = 4'h5;
  localparam logic [3:0] IDX_MAX       = 4'h5;

  // control register fields
  localparam int unsigned CTRL_AI_BIT  = 4;
  localparam int unsigned CTRL_IDX_LSB = 0;
  localparam int unsigned CTRL_IDX_W   = 4;
  localparam logic [7:0]  CTRL_RST     = 8'h00;

  // selector codes per variant
  localparam logic [1:0] SEL_LOW   = OUT_DIMMER ? 2'b01 : 2'b00;
  localparam logic [1:0] SEL_OFF   = OUT_DIMMER ? 2'b00 : 2'b01;
  localparam logic [1:0] SEL_RATE1 = 2'b10;
  localparam logic [1:0] SEL_RATE2 = 2'b11;

  // reset values
  localparam logic [7:0] PSC_RST  = OUT_DIMMER ? 8'h00 : 8'hff;
  localparam logic [7:0] DUTY_RST = 8'h80;
  localparam logic [7:0] SEL_RST  = {4{SEL_OFF}};

  // blink timing: 256 prescaler steps of 6.25 ms give 1.6 s longest period
  localparam int unsigned BLINK_STEP_NS  = 6250000;
  localparam int unsigned BLINK_STEP_CYC = BLINK_STEP_NS / CLK_PERIOD_NS;

  // controller scl quarter period (100 kHz bus)
  localparam int unsigned SCL_QUARTER_NS  = 2500;
  localparam int unsigned SCL_QUARTER_CYC = SCL_QUARTER_NS / CLK_PERIOD_NS;

  // controller register map (byte addresses)
  localparam logic [7:0]  HOST_CMD_OFS     = 8'h00;
  localparam logic [7:0]  HOST_STAT_OFS    = 8'h04;
  localparam int unsigned CMD_DATA_LSB     = 0;
  localparam int unsigned CMD_OP_LSB       = 8;
  localparam int unsigned CMD_NACK_BIT     = 10;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_NOACK_BIT   = 1;
  localparam int unsigned STAT_REFUSED_BIT = 2;
  localparam int unsigned STAT_RX_LSB      = 8;

  typedef enum logic [1:0] {OP_START, OP_STOP, OP_WRITE, OP_READ} lio_op_t;
endpackage

/* File: tb_top.sv */
// Purpose: drives the controller over ahb-lite and judges the led device behind it
// Assumes: STEP_CYC set to 4 so blink periods are short
// Notes:   led pins resolved here with pull-ups and an external driver pattern
`define CHK(a, b) \
  begin \
    checks++; \
    if ((a) !== (b)) begin \
      fails++; \
      $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); \
    end \
  end

module tb_top import lio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int STEP = 4;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd_s;
  logic [31:0] st;
  logic [3:0]  led_o;
  logic [3:0]  led_oe;
  logic [3:0]  ext;
  wire  [3:0]  led_pin;
  int          fails;
  int          checks;

  lio_if bus_if ();
  // a pin reads low when the device pulls it or the outside drives low
  assign led_pin = ext & ~led_oe;

  lio_device #(.STEP_CYC(STEP)) lio_device_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if.device),
    .led_drv(led_o), .led_oe(led_oe), .led_sense(led_pin));
  lio_host lio_host_inst (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus(bus_if.host));
  lio_checker lio_checker_inst (.clk(clk), .rst_n(rst_n), .scl_line(bus_if.scl_line),
    .sda_line(bus_if.sda_line), .scl_m_o(bus_if.scl_m_o), .scl_m_oe(bus_if.scl_m_oe),
    .sda_m_o(bus_if.sda_m_o), .sda_m_oe(bus_if.sda_m_oe), .sda_s_o(bus_if.sda_s_o),
    .sda_s_oe(bus_if.sda_s_oe));

  always #50 clk = ~clk;

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ready and read data are flops: read at the edge, before it updates them, they are what the edge samples
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    rd_s = hrdata;
    if (n == 50) begin
      fails++;
      $display("[ERR] %0t ahb wait timeout", $time);
      wrap_up();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    `CHK(hresp, 1'b0)
  endtask

  task automatic i2c(input logic [1:0] op, input logic [7:0] d, input logic nk);
    int n;
    ahb(1'b1, HOST_CMD_OFS, {21'h0, nk, op, d});
    for (n = 0; n < 1000; n++) begin
      ahb(1'b0, HOST_STAT_OFS, 32'h0);
      if (rd_s[STAT_BUSY_BIT] === 1'b0) break;
    end
    st = rd_s;
    if (n == 1000) begin
      fails++;
      $display("[ERR] %0t controller stuck busy", $time);
      wrap_up();
    end
  endtask

  task automatic put(input logic [7:0] d);
    i2c(OP_WRITE, d, 1'b0);
    `CHK(st[STAT_NOACK_BIT], 1'b0)
  endtask

  task automatic open(input logic [7:0] ctrl);
    i2c(OP_START, 8'h00, 1'b0);
    put({DEV_ADDR, 1'b0});
    put(ctrl);
  endtask

  task automatic rd_one(input logic [7:0] ctrl);
    open(ctrl);
    i2c(OP_START, 8'h00, 1'b0);
    put({DEV_ADDR, 1'b1});
    i2c(OP_READ, 8'h00, 1'b1);
    i2c(OP_STOP, 8'h00, 1'b0);
  endtask

  // counts cycles between the second and third switch-on of a pin
  task automatic measure(input int b, output int c);
    int k;
    logic p;
    k = 0;
    c = 0;
    p = led_oe[b];
    for (int n = 0; n < 4000 && k < 3; n++) begin
      @(negedge clk);
      if (k >= 2) c++;
      if (led_oe[b] === 1'b1 && p === 1'b0) k++;
      p = led_oe[b];
    end
    @(posedge clk);
    if (k < 3) begin
      fails++;
      $display("[ERR] %0t blink edge timeout", $time);
      wrap_up();
    end
  endtask

  task automatic s_program();
    logic [7:0] prog [5] = '{8'h01, 8'h40, 8'h02, 8'h80, 8'h01};
    open(8'h11);
    foreach (prog[i]) put(prog[i]);
    i2c(OP_STOP, 8'h00, 1'b0);
    `CHK(led_oe, 4'b0001)
    `CHK(led_o, 4'h0)
  endtask

  task automatic s_burst();
    logic [7:0] want [6] = '{8'h01, 8'h40, 8'h02, 8'h80, 8'h01, 8'h0e};
    open(8'h11);
    i2c(OP_START, 8'h00, 1'b0);
    put({DEV_ADDR, 1'b1});
    for (int i = 0; i < 5; i++) begin
      i2c(OP_READ, 8'h00, 1'b0);
      `CHK(st[15:8], want[i])
    end
    i2c(OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], want[5])
    i2c(OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic s_single();
    open(8'h05);
    i2c(OP_START, 8'h00, 1'b0);
    put({DEV_ADDR, 1'b1});
    i2c(OP_READ, 8'h00, 1'b0);
    `CHK(st[15:8], 8'h01)
    i2c(OP_READ, 8'h00, 1'b1);
    `CHK(st[15:8], 8'h01)
    i2c(OP_STOP, 8'h00, 1'b0);
  endtask

  task automatic s_gpio();
    ext <= 4'b0101;
    open(8'h05);
    put(8'h00);
    i2c(OP_STOP, 8'h00, 1'b0);
    `CHK(led_oe, 4'h0)
    rd_one(8'h00);
    `CHK(st[15:8], 8'h05)
    open(8'h05);
    put(8'h01);
    i2c(OP_STOP, 8'h00, 1'b0);
    rd_one(8'h00);
    `CHK(st[15:8], 8'h04)
    ext <= 4'hf;
  endtask

  task automatic s_blink();
    int c;
    open(8'h05);
    put(8'he0);
    i2c(OP_STOP, 8'h00, 1'b0);
    measure(2, c);
    `CHK(c, 2 * STEP)
    measure(3, c);
    `CHK(c, 3 * STEP)
    open(8'h01);
    put(8'hff);
    i2c(OP_STOP, 8'h00, 1'b0);
    measure(2, c);
    `CHK(c, 256 * STEP)
  endtask

  // auto-increment read from index 0 is held back by the controller
  task automatic s_refuse();
    open(8'h10);
    i2c(OP_START, 8'h00, 1'b0);
    i2c(OP_WRITE, {DEV_ADDR, 1'b1}, 1'b0);
    `CHK(st[STAT_REFUSED_BIT], 1'b1)
    i2c(OP_STOP, 8'h00, 1'b0);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    ext = 4'hf;
    fails = 0;
    checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    s_program();
    s_burst();
    s_single();
    s_gpio();
    s_blink();
    s_refuse();
    wrap_up();
  end
endmodule
